// ===== design/mvdr_regs.sv
// Register bank of the motor vector calculation unit: supply voltage, d/q currents
// and the three phase pulse widths, reached over classic Wishbone and shared with
// the calculation unit and the PWM driver.
// Assumes one clock, an active-low asynchronous reset and a single-cycle bus master.
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module mvdr_regs #(
	parameter int ADR_W = mvdr_pkg::MVDR_ADR_W
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [mvdr_pkg::MVDR_SEL_W-1:0] wb_sel_i,
	input wire logic [mvdr_pkg::MVDR_DATA_W-1:0] wb_dat_i,
	output logic [mvdr_pkg::MVDR_DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Calculation unit updates.
	input wire logic calc_vsup_we,
	input wire logic [mvdr_pkg::MVDR_SUPPLY_W-1:0] calc_vsup_data,
	input wire logic calc_dcur_we,
	input wire logic [mvdr_pkg::MVDR_CUR_W-1:0] calc_dcur_data,
	input wire logic calc_qcur_we,
	input wire logic [mvdr_pkg::MVDR_CUR_W-1:0] calc_qcur_data,
	input wire logic [mvdr_pkg::MVDR_PHASES-1:0] calc_duty_we,
	input wire logic [mvdr_pkg::MVDR_DUTY_W-1:0] calc_duty_u,
	input wire logic [mvdr_pkg::MVDR_DUTY_W-1:0] calc_duty_v,
	input wire logic [mvdr_pkg::MVDR_DUTY_W-1:0] calc_duty_w,
	// Raw converter results of the three phase currents.
	input wire logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ia_raw,
	input wire logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ib_raw,
	input wire logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ic_raw,
	// Weight of one converter step for voltage and current.
	input wire logic [mvdr_pkg::MVDR_LSB_W-1:0] volt_lsb_weight,
	input wire logic [mvdr_pkg::MVDR_LSB_W-1:0] curr_lsb_weight,
	// Stored values for the calculation unit.
	output logic [mvdr_pkg::MVDR_SUPPLY_W-1:0] supply_voltage_value,
	output logic [mvdr_pkg::MVDR_CUR_W-1:0] d_axis_current_value,
	output logic [mvdr_pkg::MVDR_CUR_W-1:0] q_axis_current_value,
	// Phase pulse widths to the PWM driver.
	output logic [mvdr_pkg::MVDR_DUTY_W-1:0] u_phase_pulse_width,
	output logic [mvdr_pkg::MVDR_DUTY_W-1:0] v_phase_pulse_width,
	output logic [mvdr_pkg::MVDR_DUTY_W-1:0] w_phase_pulse_width,
	output logic duty_update,
	// Converter results aligned for the current computations.
	output logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ia_used,
	output logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ib_used,
	output logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ic_used,
	// Physical values in the units of the step weights.
	output logic signed [mvdr_pkg::MVDR_VPHYS_W-1:0] supply_voltage_phys,
	output logic signed [mvdr_pkg::MVDR_IPHYS_W-1:0] d_axis_current_phys,
	output logic signed [mvdr_pkg::MVDR_IPHYS_W-1:0] q_axis_current_phys
);
	import mvdr_pkg::*;

	localparam int IDX_W = ADR_W - MVDR_WORD_LSB;

	// Bus handshake state.
	logic ack_r;
	logic ack_nxt;
	logic [MVDR_DATA_W-1:0] rdata_r;
	logic [MVDR_DATA_W-1:0] rdata_nxt;

	// Decode.
	logic req;
	logic wr_commit;
	logic [IDX_W-1:0] word_idx;
	logic hit_supply;
	logic hit_dcur;
	logic hit_qcur;
	logic hit_uduty;
	logic hit_vduty;
	logic hit_wduty;
	logic hit_any;

	// Stored fields.
	logic [MVDR_SUPPLY_W-1:0] supply_q;
	logic [MVDR_CUR_W-1:0] dcur_q;
	logic [MVDR_CUR_W-1:0] qcur_q;
	logic [MVDR_DUTY_W-1:0] uduty_q;
	logic [MVDR_DUTY_W-1:0] vduty_q;
	logic [MVDR_DUTY_W-1:0] wduty_q;

	// Duty change notice and converter alignment.
	logic duty_upd_r;
	logic duty_upd_nxt;
	logic [MVDR_ADC_W-1:0] ia_r;
	logic [MVDR_ADC_W-1:0] ib_r;
	logic [MVDR_ADC_W-1:0] ic_r;
	logic [MVDR_ADC_W-1:0] ia_nxt;
	logic [MVDR_ADC_W-1:0] ib_nxt;
	logic [MVDR_ADC_W-1:0] ic_nxt;

	// Address decode on the word index; byte-offset bits are ignored.
	always_comb begin
		req = wb_cyc_i & wb_stb_i;
		word_idx = wb_adr_i[ADR_W-1:MVDR_WORD_LSB];
		hit_supply = (word_idx == IDX_W'(MVDR_OFS_SUPPLY >> MVDR_WORD_LSB));
		hit_dcur = (word_idx == IDX_W'(MVDR_OFS_DCUR >> MVDR_WORD_LSB));
		hit_qcur = (word_idx == IDX_W'(MVDR_OFS_QCUR >> MVDR_WORD_LSB));
		hit_uduty = (word_idx == IDX_W'(MVDR_OFS_UDUTY >> MVDR_WORD_LSB));
		hit_vduty = (word_idx == IDX_W'(MVDR_OFS_VDUTY >> MVDR_WORD_LSB));
		hit_wduty = (word_idx == IDX_W'(MVDR_OFS_WDUTY >> MVDR_WORD_LSB));
		hit_any = hit_supply | hit_dcur | hit_qcur | hit_uduty | hit_vduty | hit_wduty;
	end

	// A write lands on the edge at which the master sees ack, so an aborted cycle
	// never changes a register. Unmapped writes are acknowledged and dropped.
	assign wr_commit = req & wb_we_i & ack_r;

	// Ack follows one cycle after the request and drops the cycle after; read data
	// is captured with it and reserved upper bits are filled with zeros.
	always_comb begin
		ack_nxt = req & ~ack_r;
		rdata_nxt = rdata_r;
		if (req & ~ack_r) begin
			rdata_nxt = MVDR_RD_ZERO;
			if (!wb_we_i) begin
				if (hit_supply) begin
					rdata_nxt = {{(MVDR_DATA_W-MVDR_SUPPLY_W){1'b0}}, supply_q};
				end else if (hit_dcur) begin
					rdata_nxt = dcur_q;
				end else if (hit_qcur) begin
					rdata_nxt = qcur_q;
				end else if (hit_uduty) begin
					rdata_nxt = {{(MVDR_DATA_W-MVDR_DUTY_W){1'b0}}, uduty_q};
				end else if (hit_vduty) begin
					rdata_nxt = {{(MVDR_DATA_W-MVDR_DUTY_W){1'b0}}, vduty_q};
				end else if (hit_wduty) begin
					rdata_nxt = {{(MVDR_DATA_W-MVDR_DUTY_W){1'b0}}, wduty_q};
				end
			end
		end
	end

	// Bus handshake registers.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
			rdata_r <= MVDR_RD_ZERO;
		end else begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// Supply voltage; only the two low byte lanes are stored.
	mvdr_reg_cell #(
		.W(MVDR_SUPPLY_W),
		.RST(MVDR_SUPPLY_RST)
	) u_supply (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.bus_we(wr_commit & hit_supply),
		.bus_sel(wb_sel_i),
		.bus_wdata(wb_dat_i),
		.hw_we(calc_vsup_we),
		.hw_data(calc_vsup_data),
		.q(supply_q)
	);

	// D-axis current, all four byte lanes.
	mvdr_reg_cell #(
		.W(MVDR_CUR_W),
		.RST(MVDR_CUR_RST)
	) u_dcur (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.bus_we(wr_commit & hit_dcur),
		.bus_sel(wb_sel_i),
		.bus_wdata(wb_dat_i),
		.hw_we(calc_dcur_we),
		.hw_data(calc_dcur_data),
		.q(dcur_q)
	);

	// Q-axis current, all four byte lanes.
	mvdr_reg_cell #(
		.W(MVDR_CUR_W),
		.RST(MVDR_CUR_RST)
	) u_qcur (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.bus_we(wr_commit & hit_qcur),
		.bus_sel(wb_sel_i),
		.bus_wdata(wb_dat_i),
		.hw_we(calc_qcur_we),
		.hw_data(calc_qcur_data),
		.q(qcur_q)
	);

	// U-phase pulse width.
	mvdr_reg_cell #(
		.W(MVDR_DUTY_W),
		.RST(MVDR_DUTY_RST)
	) u_uduty (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.bus_we(wr_commit & hit_uduty),
		.bus_sel(wb_sel_i),
		.bus_wdata(wb_dat_i),
		.hw_we(calc_duty_we[0]),
		.hw_data(calc_duty_u),
		.q(uduty_q)
	);

	// V-phase pulse width.
	mvdr_reg_cell #(
		.W(MVDR_DUTY_W),
		.RST(MVDR_DUTY_RST)
	) u_vduty (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.bus_we(wr_commit & hit_vduty),
		.bus_sel(wb_sel_i),
		.bus_wdata(wb_dat_i),
		.hw_we(calc_duty_we[1]),
		.hw_data(calc_duty_v),
		.q(vduty_q)
	);

	// W-phase pulse width.
	mvdr_reg_cell #(
		.W(MVDR_DUTY_W),
		.RST(MVDR_DUTY_RST)
	) u_wduty (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.bus_we(wr_commit & hit_wduty),
		.bus_sel(wb_sel_i),
		.bus_wdata(wb_dat_i),
		.hw_we(calc_duty_we[2]),
		.hw_data(calc_duty_w),
		.q(wduty_q)
	);

	// Physical supply voltage: full scale is the step weight shifted up by 12,
	// and the product is taken down by 15 bits.
	mvdr_scale #(
		.VW(MVDR_SUPPLY_W),
		.VSIGNED(1'b0),
		.LW(MVDR_LSB_W),
		.FS_SHIFT(MVDR_VFS_SHIFT),
		.FRAC(MVDR_VFRAC),
		.OW(MVDR_VPHYS_W)
	) u_vscale (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.value(supply_q),
		.lsb_weight(volt_lsb_weight),
		.phys(supply_voltage_phys)
	);

	// Physical d-axis current; the stored word is signed, so the product is too.
	mvdr_scale #(
		.VW(MVDR_CUR_W),
		.VSIGNED(1'b1),
		.LW(MVDR_LSB_W),
		.FS_SHIFT(MVDR_IFS_SHIFT),
		.FRAC(MVDR_IFRAC),
		.OW(MVDR_IPHYS_W)
	) u_dscale (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.value(dcur_q),
		.lsb_weight(curr_lsb_weight),
		.phys(d_axis_current_phys)
	);

	// Physical q-axis current, same scaling as the d axis.
	mvdr_scale #(
		.VW(MVDR_CUR_W),
		.VSIGNED(1'b1),
		.LW(MVDR_LSB_W),
		.FS_SHIFT(MVDR_IFS_SHIFT),
		.FRAC(MVDR_IFRAC),
		.OW(MVDR_IPHYS_W)
	) u_qscale (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.value(qcur_q),
		.lsb_weight(curr_lsb_weight),
		.phys(q_axis_current_phys)
	);

	// The PWM driver is told when any phase width may have changed, so it can
	// reload its compare values at the next carrier boundary instead of polling.
	always_comb begin
		duty_upd_nxt = (|calc_duty_we)
			| (wr_commit & (hit_uduty | hit_vduty | hit_wduty));
	end

	// Converter results keep bits 15 to 4; the low nibble is forced to zero
	// so a noisy or misaligned source cannot leak into the current maths.
	always_comb begin
		ia_nxt = adc_ia_raw & MVDR_ADC_MASK;
		ib_nxt = adc_ib_raw & MVDR_ADC_MASK;
		ic_nxt = adc_ic_raw & MVDR_ADC_MASK;
	end

	// Side-band registers; everything clears on reset.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			duty_upd_r <= 1'b0;
			ia_r <= '0;
			ib_r <= '0;
			ic_r <= '0;
		end else begin
			duty_upd_r <= duty_upd_nxt;
			ia_r <= ia_nxt;
			ib_r <= ib_nxt;
			ic_r <= ic_nxt;
		end
	end

	// Stored values go straight out of their flip-flops.
	assign supply_voltage_value = supply_q;
	assign d_axis_current_value = dcur_q;
	assign q_axis_current_value = qcur_q;
	assign u_phase_pulse_width = uduty_q;
	assign v_phase_pulse_width = vduty_q;
	assign w_phase_pulse_width = wduty_q;
	assign duty_update = duty_upd_r;
	assign adc_ia_used = ia_r;
	assign adc_ib_used = ib_r;
	assign adc_ic_used = ic_r;
endmodule

// ===== design/mvdr_pkg.sv
// Constants shared by the motor vector data register bank and its helpers.
// Assumes a 32-bit classic Wishbone register bus with byte-lane selects.
package mvdr_pkg;
	// Bus geometry.
	localparam int MVDR_DATA_W = 32;
	localparam int MVDR_SEL_W = 4;
	localparam int MVDR_ADR_W = 8;
	localparam int MVDR_BYTE_W = 8;
	localparam int MVDR_WORD_LSB = 2;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0] MVDR_OFS_SUPPLY = 8'h00;
	localparam logic [7:0] MVDR_OFS_DCUR = 8'h04;
	localparam logic [7:0] MVDR_OFS_QCUR = 8'h08;
	localparam logic [7:0] MVDR_OFS_UDUTY = 8'h0C;
	localparam logic [7:0] MVDR_OFS_VDUTY = 8'h10;
	localparam logic [7:0] MVDR_OFS_WDUTY = 8'h14;

	// Field widths; the narrow fields sit in bits 15 to 0.
	localparam int MVDR_SUPPLY_W = 16;
	localparam int MVDR_CUR_W = 32;
	localparam int MVDR_DUTY_W = 16;
	localparam int MVDR_PHASES = 3;

	// Reset values.
	localparam logic [15:0] MVDR_SUPPLY_RST = 16'h0000;
	localparam logic [31:0] MVDR_CUR_RST = 32'h0000_0000;
	localparam logic [15:0] MVDR_DUTY_RST = 16'h0000;
	localparam logic [31:0] MVDR_RD_ZERO = 32'h0000_0000;

	// Converter results: the valid field is bits 15 to 4, bits 3 to 0 read as zero.
	localparam int MVDR_ADC_W = 16;
	localparam logic [15:0] MVDR_ADC_MASK = 16'hFFF0;

	// Scaling: full scale is one converter step shifted up, results shifted down.
	localparam int MVDR_LSB_W = 16;
	localparam int MVDR_VFS_SHIFT = 12;
	localparam int MVDR_VFRAC = 15;
	localparam int MVDR_IFS_SHIFT = 11;
	localparam int MVDR_IFRAC = 31;
	localparam int MVDR_VPHYS_W = MVDR_SUPPLY_W + MVDR_LSB_W + MVDR_VFS_SHIFT + 2 - MVDR_VFRAC;
	localparam int MVDR_IPHYS_W = MVDR_CUR_W + MVDR_LSB_W + MVDR_IFS_SHIFT + 2 - MVDR_IFRAC;
endpackage

// ===== design/mvdr_reg_cell.sv
// One storage word of the register bank, writable by the bus and the calculation unit.
// Assumes the bus strobe is a single-cycle pulse already qualified by address decode.
`timescale 1ns/10ps
module mvdr_reg_cell #(
	parameter int W = 16,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Bus write with byte lanes.
	input wire logic bus_we,
	input wire logic [mvdr_pkg::MVDR_SEL_W-1:0] bus_sel,
	input wire logic [mvdr_pkg::MVDR_DATA_W-1:0] bus_wdata,
	// Calculation unit write.
	input wire logic hw_we,
	input wire logic [W-1:0] hw_data,
	// Stored value.
	output logic [W-1:0] q
);
	import mvdr_pkg::*;

	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// Only byte lanes inside the field are stored, so upper reserved lanes are dropped.
	always_comb begin
		q_nxt = q_r;
		if (bus_we) begin
			for (int b = 0; b < W / MVDR_BYTE_W; b++) begin
				if (bus_sel[b]) begin
					q_nxt[b*MVDR_BYTE_W +: MVDR_BYTE_W] = bus_wdata[b*MVDR_BYTE_W +: MVDR_BYTE_W];
				end
			end
		end else if (hw_we) begin
			q_nxt = hw_data;
		end
	end

	// Storage clears to its reset value.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			q_r <= RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign q = q_r;
endmodule

// ===== design/mvdr_scale.sv
// Converts a stored fixed-point word to physical units from the converter step weight.
// Assumes the step weight input is steady; the result lags its inputs by one clock.
`timescale 1ns/10ps
module mvdr_scale #(
	parameter int VW = 16,
	parameter bit VSIGNED = 1'b0,
	parameter int LW = 16,
	parameter int FS_SHIFT = 12,
	parameter int FRAC = 15,
	parameter int OW = VW + LW + FS_SHIFT + 2 - FRAC
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Stored value and weight of one converter step.
	input wire logic [VW-1:0] value,
	input wire logic [LW-1:0] lsb_weight,
	// Physical result, signed.
	output logic signed [OW-1:0] phys
);
	localparam int PW = VW + LW + FS_SHIFT + 2;

	logic signed [VW:0] v_ext;
	logic signed [LW+FS_SHIFT:0] full_scale;
	logic signed [PW-1:0] prod;
	logic signed [OW-1:0] phys_r;
	logic signed [OW-1:0] phys_nxt;

	// Full scale is the step weight times a power of two; value times full scale over 2^FRAC.
	always_comb begin
		v_ext = {(VSIGNED ? value[VW-1] : 1'b0), value};
		full_scale = {1'b0, lsb_weight, {FS_SHIFT{1'b0}}};
		prod = v_ext * full_scale;
		phys_nxt = OW'(prod >>> FRAC);
	end

	// Registered so the wide multiply does not sit on the output path.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phys_r <= '0;
		end else begin
			phys_r <= phys_nxt;
		end
	end

	assign phys = phys_r;
endmodule

// ===== verification/mvdr_pwm_model.sv
// Behavioural PWM driver that takes the three phase pulse widths on each update pulse.
// Assumes the register bank presents settled widths in the cycle of duty_update.
`timescale 1ns/10ps
module mvdr_pwm_model (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Pulse widths offered by the register bank.
	input wire logic [mvdr_pkg::MVDR_DUTY_W-1:0] u_phase_pulse_width,
	input wire logic [mvdr_pkg::MVDR_DUTY_W-1:0] v_phase_pulse_width,
	input wire logic [mvdr_pkg::MVDR_DUTY_W-1:0] w_phase_pulse_width,
	input wire logic duty_update,
	// Widths the generator is running with.
	output logic [mvdr_pkg::MVDR_DUTY_W-1:0] u_applied,
	output logic [mvdr_pkg::MVDR_DUTY_W-1:0] v_applied,
	output logic [mvdr_pkg::MVDR_DUTY_W-1:0] w_applied
);
	import mvdr_pkg::*;
	// Widths are taken only on the pulse, so a stale pulse shows up as an old width.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			u_applied <= 16'h0000;
			v_applied <= 16'h0000;
			w_applied <= 16'h0000;
		end else if (duty_update) begin
			u_applied <= u_phase_pulse_width;
			v_applied <= v_phase_pulse_width;
			w_applied <= w_phase_pulse_width;
		end
	end
endmodule

// ===== verification/mvdr_regs_checker.sv
// Concurrent checks on the ports of the motor vector data register bank.
// Assumes a classic single-cycle bus master and no calc write during a bus read.
`timescale 1ns/10ps
module mvdr_regs_checker (
	// Clock, reset and bus.
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [mvdr_pkg::MVDR_ADR_W-1:0] wb_adr_i,
	input wire logic [mvdr_pkg::MVDR_SEL_W-1:0] wb_sel_i,
	input wire logic [mvdr_pkg::MVDR_DATA_W-1:0] wb_dat_i,
	input wire logic [mvdr_pkg::MVDR_DATA_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Calculation and converter side.
	input wire logic [mvdr_pkg::MVDR_PHASES-1:0] calc_duty_we,
	input wire logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ia_raw,
	input wire logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ia_used,
	input wire logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ib_raw,
	input wire logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ib_used,
	input wire logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ic_raw,
	input wire logic [mvdr_pkg::MVDR_ADC_W-1:0] adc_ic_used,
	input wire logic [mvdr_pkg::MVDR_LSB_W-1:0] volt_lsb_weight,
	input wire logic [mvdr_pkg::MVDR_LSB_W-1:0] curr_lsb_weight,
	// Stored and derived values.
	input wire logic [mvdr_pkg::MVDR_SUPPLY_W-1:0] supply_voltage_value,
	input wire logic [mvdr_pkg::MVDR_CUR_W-1:0] d_axis_current_value,
	input wire logic [mvdr_pkg::MVDR_CUR_W-1:0] q_axis_current_value,
	input wire logic [mvdr_pkg::MVDR_DUTY_W-1:0] u_phase_pulse_width,
	input wire logic [mvdr_pkg::MVDR_DUTY_W-1:0] v_phase_pulse_width,
	input wire logic [mvdr_pkg::MVDR_DUTY_W-1:0] w_phase_pulse_width,
	input wire logic duty_update,
	input wire logic signed [mvdr_pkg::MVDR_VPHYS_W-1:0] supply_voltage_phys,
	input wire logic signed [mvdr_pkg::MVDR_IPHYS_W-1:0] d_axis_current_phys,
	input wire logic signed [mvdr_pkg::MVDR_IPHYS_W-1:0] q_axis_current_phys
);
	import mvdr_pkg::*;
	// Reference products, kept wide so that no scaling bit is lost before the shift.
	wire [43:0] vp = supply_voltage_value * {volt_lsb_weight, 12'h000};
	wire [28:0] vs = vp[43:15];
	wire signed [27:0] i_fs = $signed({1'b0, curr_lsb_weight, 11'h000});
	wire signed [59:0] dp = $signed(d_axis_current_value) * i_fs;
	wire signed [29:0] ds = {dp[59], dp[59:31]};
	wire signed [59:0] qp = $signed(q_axis_current_value) * i_fs;
	wire signed [29:0] qs = {qp[59], qp[59:31]};
	wire rd_ack = wb_ack_o && !wb_we_i;
	wire wr_ack = wb_ack_o && wb_we_i && wb_sel_i == 4'hF;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Bus answers, read images, write commits, duty update pulse, converter alignment and scaling.
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_supply_read: assert property (rd_ack && wb_adr_i[7:2] == 6'd0
		|-> wb_dat_o == {16'h0000, supply_voltage_value})
		else $error("supply read image wrong");
	a_dcur_write: assert property (wr_ack && wb_adr_i[7:2] == 6'd1
		|=> d_axis_current_value == $past(wb_dat_i))
		else $error("d current write lost");
	a_qcur_write: assert property (wr_ack && wb_adr_i[7:2] == 6'd2
		|=> q_axis_current_value == $past(wb_dat_i))
		else $error("q current write lost");
	a_u_read: assert property (rd_ack && wb_adr_i[7:2] == 6'd3
		|-> wb_dat_o == {16'h0000, u_phase_pulse_width})
		else $error("u read image wrong");
	a_v_read: assert property (rd_ack && wb_adr_i[7:2] == 6'd4
		|-> wb_dat_o == {16'h0000, v_phase_pulse_width})
		else $error("v read image wrong");
	a_w_read: assert property (rd_ack && wb_adr_i[7:2] == 6'd5
		|-> wb_dat_o == {16'h0000, w_phase_pulse_width})
		else $error("w read image wrong");
	a_duty_pulse: assert property ((|calc_duty_we)
		|| (wb_ack_o && wb_we_i && wb_adr_i[7:2] inside {6'd3, 6'd4, 6'd5}) |=> duty_update)
		else $error("duty update pulse missing");
	a_adc_align: assert property ($past(nrst)
		|-> adc_ia_used == ($past(adc_ia_raw) & MVDR_ADC_MASK))
		else $error("converter result not aligned");
	a_adc_bc_align: assert property ($past(nrst)
		|-> adc_ib_used == ($past(adc_ib_raw) & MVDR_ADC_MASK)
		&& adc_ic_used == ($past(adc_ic_raw) & MVDR_ADC_MASK))
		else $error("b or c converter result not aligned");
	a_vphys_scale: assert property ($past(nrst)
		|-> supply_voltage_phys == {2'b00, $past(vs)})
		else $error("supply scaling wrong");
	a_dphys_scale: assert property ($past(nrst) |-> d_axis_current_phys == $past(ds))
		else $error("d current scaling wrong");
	a_qphys_scale: assert property ($past(nrst) |-> q_axis_current_phys == $past(qs))
		else $error("q current scaling wrong");
	// Main scenarios.
	c_write: cover property (wb_ack_o && wb_we_i);
	c_calc_duty: cover property (calc_duty_we == 3'b111);
	c_unmapped: cover property (rd_ack && wb_adr_i == 8'h18);
endmodule
bind mvdr_regs mvdr_regs_checker mvdr_regs_checker_inst (.*);

// ===== verification/mvdr_regs_tb_top.sv
// Self-checking bench of the register bank with a PWM driver model on its far side.
// Assumes a single-cycle bus answer; reads are checked from a queue of expected words.
`timescale 1ns/10ps
module mvdr_regs_tb_top;
	import mvdr_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o, d_axis_current_value, q_axis_current_value;
	logic wb_ack_o, duty_update;
	logic calc_vsup_we = 1'b0, calc_dcur_we = 1'b0, calc_qcur_we = 1'b0;
	logic [2:0] calc_duty_we = 3'h0;
	logic [15:0] calc_vsup_data = 16'h0000, calc_duty_u = 16'h0000;
	logic [15:0] calc_duty_v = 16'h0000, calc_duty_w = 16'h0000;
	logic [31:0] calc_dcur_data = 32'h0000_0000, calc_qcur_data = 32'h0000_0000;
	logic [15:0] adc_ia_raw = 16'h0000, adc_ib_raw = 16'h0000, adc_ic_raw = 16'h0000;
	logic [15:0] volt_lsb_weight = 16'h0000, curr_lsb_weight = 16'h0000;
	logic [15:0] supply_voltage_value, u_phase_pulse_width, v_phase_pulse_width;
	logic [15:0] w_phase_pulse_width, adc_ia_used, adc_ib_used, adc_ic_used;
	logic [15:0] u_applied, v_applied, w_applied;
	logic signed [30:0] supply_voltage_phys;
	logic signed [29:0] d_axis_current_phys, q_axis_current_phys;
	logic [31:0] exp_q[$];
	logic [31:0] sh[6];
	logic [31:0] msk[6] = '{32'h0000_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF,
		32'h0000_FFFF, 32'h0000_FFFF};
	logic signed [59:0] dexp;
	logic [63:0] vexp;
	int err_count = 0, comparisons = 0, cyc_cnt = 0;

	mvdr_regs mvdr_regs_inst (.*);
	mvdr_pwm_model mvdr_pwm_model_inst (.*);

	// Free-running 40 MHz clock.
	always #12.5 ref_clk = ~ref_clk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One classic cycle; the request stays put until ack is seen at a rising edge.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0000_0000, 4'hF);
	endtask

	// Every read answer is matched against the oldest expected word.
	always @(posedge ref_clk) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			check(wb_dat_o, exp_q.pop_front());
		end
	end

	// Converter results change every cycle so alignment is exercised throughout.
	always @(posedge ref_clk) begin
		adc_ia_raw <= 16'($urandom);
		adc_ib_raw <= 16'($urandom);
		adc_ic_raw <= 16'($urandom);
	end

	// A hang ends the run as a failure long after the sequence should be done.
	always @(posedge ref_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			err_count++;
			test_done;
		end
	end

	initial begin
		void'($urandom(61360));
		volt_lsb_weight <= 16'($urandom);
		curr_lsb_weight <= 16'($urandom);
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		// All words, and one unmapped word, read zero after reset.
		for (int i = 0; i < 7; i++) begin
			rd(8'(i * 4), 32'h0000_0000);
		end
		// Random words, then all ones, read back through each field's width.
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 6; i++) begin
				sh[i] = (r == 1) ? 32'hFFFF_FFFF : $urandom;
				wb(1'b1, 8'(i * 4), sh[i], 4'hF);
				sh[i] &= msk[i];
			end
			for (int i = 0; i < 6; i++) begin
				rd(8'(i * 4), sh[i]);
			end
		end
		// Reserved lanes of a duty word are dropped; one lane lands by itself.
		wb(1'b1, 8'h0C, 32'h1234_5678, 4'hC);
		wb(1'b1, 8'h0C, 32'h0000_A500, 4'h2);
		sh[3][15:8] = 8'hA5;
		rd(8'h0C, sh[3]);
		check({16'h0000, u_applied}, sh[3]);
		wb(1'b1, 8'h18, 32'hFFFF_FFFF, 4'hF);
		rd(8'h18, 32'h0000_0000);
		// The calculation unit loads every register at one edge.
		@(posedge ref_clk);
		{calc_vsup_we, calc_dcur_we, calc_qcur_we, calc_duty_we} <= 6'h3F;
		{calc_vsup_data, calc_duty_u, calc_duty_v, calc_duty_w} <= {$urandom, $urandom};
		{calc_dcur_data, calc_qcur_data} <= {$urandom, $urandom};
		@(posedge ref_clk);
		{calc_vsup_we, calc_dcur_we, calc_qcur_we, calc_duty_we} <= 6'h00;
		sh = '{{16'h0000, calc_vsup_data}, calc_dcur_data, calc_qcur_data,
			{16'h0000, calc_duty_u}, {16'h0000, calc_duty_v}, {16'h0000, calc_duty_w}};
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4), sh[i]);
		end
		check({u_applied, v_applied}, {calc_duty_u, calc_duty_v});
		check({16'h0000, w_applied}, sh[5]);
		// Negative full scale current and the supply word scale with the step weights.
		wb(1'b1, 8'h04, 32'h8000_0000, 4'hF);
		repeat (3) @(posedge ref_clk);
		dexp = $signed(32'h8000_0000) * $signed({1'b0, curr_lsb_weight, 11'h000});
		check({2'b00, d_axis_current_phys}, {2'b00, dexp[59], dexp[59:31]});
		vexp = (64'(sh[0]) * {volt_lsb_weight, 12'h000}) >> 15;
		check({1'b0, supply_voltage_phys}, vexp[31:0]);
		// A reset in mid-run must clear every word that the earlier scenarios left behind.
		nrst <= 1'b0;
		@(posedge ref_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4), 32'h0000_0000);
		end
		check({u_applied, v_applied}, 32'h0000_0000);
		@(posedge ref_clk);
		test_done;
	end
endmodule
